// ### verilog/cps_top.sv
// card punch status, check and operator control logic
`timescale 1ns/1ps
module cps_top (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [cps_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [cps_pkg::DATA_W-1:0]    pwdata,
	output logic      [cps_pkg::DATA_W-1:0]    prdata,
	output logic                               pready,
	output logic                               pslverr,
	output logic                               pirq,
	// mechanism sensors
	input  wire logic                          card_at_station,
	input  wire logic                          feed_fault,
	input  wire logic                          auto_eject,
	input  wire logic                          transport_open,
	input  wire logic                          die_missing,
	input  wire logic                          covers_missing,
	input  wire logic                          primary_full,
	input  wire logic                          aux_full,
	input  wire logic                          error_full,
	input  wire logic                          punching_busy,
	input  wire logic                          feed_line_empty,
	// operator panel buttons, high while pressed
	input  wire logic [cps_pkg::CMD_N-1:0]     panel_btn,
	// row data from host and read station
	input  wire logic                          row_valid,
	input  wire logic [cps_pkg::NBITS_W-1:0]   row_nbits,
	input  wire logic [cps_pkg::ROW_BITS-1:0]  row_data,
	input  wire logic                          card_done,
	input  wire logic                          read_valid,
	input  wire logic [cps_pkg::HOLES_W-1:0]   read_holes,
	// status and mechanism control
	output logic                               unavailable,
	output logic                               feed_check,
	output logic                               punch_check,
	output logic                               full_check,
	output logic                               punch_enable,
	output logic                               feed_enable,
	output logic                               transport_run,
	output logic                               to_error_stacker
);
	import cps_pkg::*;

	// ==========================================================
	// row checker
	cps_row_if rif ();

	assign rif.row_valid  = row_valid;
	assign rif.row_nbits  = row_nbits;
	assign rif.row_data   = row_data;
	assign rif.card_done  = card_done;
	assign rif.read_valid = read_valid;
	assign rif.read_holes = read_holes;

	cps_row_check u_row_check (
		.pclk    (pclk),
		.presetn (presetn),
		.rif     (rif.chk)
	);

	// ==========================================================
	// declarations
	cps_state_type       state_r, state_nxt;
	logic [CMD_N-1:0]    btn_q_r, btn_q_nxt;
	logic [CMD_N-1:0]    cmd;
	logic                feed_check_r, feed_check_nxt;
	logic                punch_check_r, punch_check_nxt;
	logic                full_check_r, full_check_nxt;
	logic                unavail_r, unavail_nxt;
	logic                punch_en_r, punch_en_nxt;
	logic                feed_en_r, feed_en_nxt;
	logic                transport_r, transport_nxt;
	logic                err_stk_r, err_stk_nxt;
	logic                cond_any;
	logic                feed_set;
	logic                punch_set;
	logic [IRQ_N-1:0]    irq_evt;
	logic [IRQ_N-1:0]    irq_stat;
	logic [IRQ_N-1:0]    irq_clr;
	logic                irq_w;
	logic                setup;
	logic                access;
	logic                wr;
	logic                hit;
	logic [DATA_W-1:0]   rd_mux;
	logic [DATA_W-1:0]   prdata_r, prdata_nxt;
	logic                pready_r, pready_nxt;
	logic                pslverr_r, pslverr_nxt;
	logic                pirq_r, pirq_nxt;
	logic [IRQ_N-1:0]    irq_en_r, irq_en_nxt;
	assign rif.full_check = full_check_r;

	// ==========================================================
	// apb decode
	always_comb begin
		setup  = psel && !penable;
		access = psel && penable && pready_r;
		wr     = access && pwrite;
		hit    = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
		         (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_CLR) ||
		         (paddr == OFF_IRQ_EN) || (paddr == OFF_CARD_INFO);
		rd_mux = '0;
		case (paddr)
			OFF_STATUS: begin
				rd_mux[STAT_STATE_LSB +: 2] = state_r;
				rd_mux[STAT_UNAVAIL]        = unavail_r;
				rd_mux[STAT_FEED_CHK]       = feed_check_r;
				rd_mux[STAT_PUNCH_CHK]      = punch_check_r;
				rd_mux[STAT_FULL_CHK]       = full_check_r;
				rd_mux[STAT_COND_ANY]       = cond_any;
			end
			OFF_IRQ_STAT: begin
				rd_mux[IRQ_N-1:0] = irq_stat;
			end
			OFF_IRQ_EN: begin
				rd_mux[IRQ_N-1:0] = irq_en_r;
			end
			OFF_CARD_INFO: begin
				rd_mux[INFO_ROWS_LSB +: ROWCNT_W] = rif.rows_last;
				rd_mux[INFO_HOLES_LSB +: HOLES_W] = rif.holes_exp;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
		pready_nxt  = setup;
		pslverr_nxt = setup && !hit;
		prdata_nxt  = prdata_r;
		if (setup) begin
			prdata_nxt = pwrite ? '0 : rd_mux;
		end
		irq_en_nxt = irq_en_r;
		if (wr && paddr == OFF_IRQ_EN) begin
			irq_en_nxt = pwdata[IRQ_N-1:0];
		end
		irq_clr = '0;
		if (wr && paddr == OFF_IRQ_CLR) begin
			irq_clr = pwdata[IRQ_N-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			irq_en_r  <= IRQ_EN_RST;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_en_r  <= irq_en_nxt;
		end
	end

	// ==========================================================
	// commands: panel press edge or ctrl write
	always_comb begin
		btn_q_nxt = panel_btn;
		cmd       = panel_btn & ~btn_q_r;
		if (wr && paddr == OFF_CTRL) begin
			cmd = cmd | pwdata[CMD_N-1:0];
		end
	end

	// ==========================================================
	// conditions and error flags
	always_comb begin
		cond_any = !card_at_station || feed_check_r || transport_open || die_missing ||
		           covers_missing || punch_check_r || primary_full || aux_full ||
		           error_full;
		feed_set  = !card_at_station && feed_fault && !auto_eject;
		punch_set = rif.bits_err || rif.count_err || rif.hole_err;
		// only reset clears; start and runout leave flags, set wins
		feed_check_nxt  = feed_set || (feed_check_r && !cmd[CMD_RESET]);
		punch_check_nxt = punch_set || (punch_check_r && !cmd[CMD_RESET]);
		full_check_nxt  = full_check_r ^ cmd[CMD_CHKMODE];
	end

	// ==========================================================
	// unit state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_NOT_READY: begin
				if (cmd[CMD_RUNOUT]) begin
					state_nxt = ST_RUNOUT;
				end else if (cmd[CMD_START] && !cond_any) begin
					state_nxt = ST_READY;
				end
			end
			ST_READY: begin
				if (cmd[CMD_STOP]) begin
					state_nxt = punching_busy ? ST_STOPPING : ST_NOT_READY;
				end else if (cond_any) begin
					state_nxt = ST_NOT_READY;
				end
			end
			ST_STOPPING: begin
				if (!punching_busy) begin
					state_nxt = ST_NOT_READY;
				end
			end
			ST_RUNOUT: begin
				if (feed_line_empty) begin
					state_nxt = ST_NOT_READY;
				end
			end
			default: begin
				state_nxt = ST_NOT_READY;
			end
		endcase
		unavail_nxt   = cond_any || (state_nxt == ST_NOT_READY) ||
		                (state_nxt == ST_RUNOUT);
		punch_en_nxt  = ((state_nxt == ST_READY) || (state_nxt == ST_STOPPING)) &&
		                !cond_any;
		feed_en_nxt   = (state_nxt == ST_READY) && !cond_any;
		transport_nxt = (state_nxt == ST_READY) || (state_nxt == ST_STOPPING) ||
		                (state_nxt == ST_RUNOUT);
		err_stk_nxt   = (state_nxt == ST_RUNOUT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r       <= ST_NOT_READY;
			btn_q_r       <= '0;
			feed_check_r  <= 1'b0;
			punch_check_r <= 1'b0;
			full_check_r  <= FULL_CHECK_RST;
			unavail_r     <= 1'b1;
			punch_en_r    <= 1'b0;
			feed_en_r     <= 1'b0;
			transport_r   <= 1'b0;
			err_stk_r     <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			btn_q_r       <= btn_q_nxt;
			feed_check_r  <= feed_check_nxt;
			punch_check_r <= punch_check_nxt;
			full_check_r  <= full_check_nxt;
			unavail_r     <= unavail_nxt;
			punch_en_r    <= punch_en_nxt;
			feed_en_r     <= feed_en_nxt;
			transport_r   <= transport_nxt;
			err_stk_r     <= err_stk_nxt;
		end
	end

	// ==========================================================
	// interrupts
	always_comb begin
		irq_evt              = '0;
		irq_evt[IRQ_FEED]    = feed_set;
		irq_evt[IRQ_PUNCH]   = punch_set;
		irq_evt[IRQ_UNAVAIL] = unavail_nxt && !unavail_r;
		irq_evt[IRQ_STOPPED] = (state_r == ST_STOPPING) && (state_nxt == ST_NOT_READY);
		pirq_nxt             = irq_w;
	end

	cps_irq #(
		.N (IRQ_N)
	) u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.evt     (irq_evt),
		.clr     (irq_clr),
		.en      (irq_en_r),
		.status  (irq_stat),
		.irq     (irq_w)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pirq_r <= 1'b0;
		end else begin
			pirq_r <= pirq_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign pirq             = pirq_r;
	assign unavailable      = unavail_r;
	assign feed_check       = feed_check_r;
	assign punch_check      = punch_check_r;
	assign full_check       = full_check_r;
	assign punch_enable     = punch_en_r;
	assign feed_enable      = feed_en_r;
	assign transport_run    = transport_r;
	assign to_error_stacker = err_stk_r;

endmodule : cps_top

// ### verilog/cps_pkg.sv
// constants, register map and types of the card punch status logic
package cps_pkg;

	// ==========================================================
	// card geometry
	localparam int ROW_BITS      = 80;
	localparam int ROWS_PER_CARD = 12;
	localparam int NBITS_W       = 7;
	localparam int ROWCNT_W      = 4;
	localparam int HOLES_W       = 10;

	// ==========================================================
	// apb register map
	localparam int              ADDR_W        = 8;
	localparam int              DATA_W        = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CARD_INFO = 8'h14;

	// ==========================================================
	// command bits (ctrl write, panel buttons)
	localparam int CMD_START   = 0;
	localparam int CMD_STOP    = 1;
	localparam int CMD_RESET   = 2;
	localparam int CMD_CHKMODE = 3;
	localparam int CMD_RUNOUT  = 4;
	localparam int CMD_N       = 5;

	// ==========================================================
	// status and card info register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_UNAVAIL   = 2;
	localparam int STAT_FEED_CHK  = 3;
	localparam int STAT_PUNCH_CHK = 4;
	localparam int STAT_FULL_CHK  = 5;
	localparam int STAT_COND_ANY  = 6;
	localparam int INFO_ROWS_LSB  = 0;
	localparam int INFO_HOLES_LSB = 16;

	// ==========================================================
	// interrupt bits
	localparam int IRQ_FEED    = 0;
	localparam int IRQ_PUNCH   = 1;
	localparam int IRQ_UNAVAIL = 2;
	localparam int IRQ_STOPPED = 3;
	localparam int IRQ_N       = 4;

	// ==========================================================
	// reset values
	localparam logic             FULL_CHECK_RST = 1'b1;
	localparam logic [IRQ_N-1:0] IRQ_EN_RST     = 4'h0;

	typedef enum logic [1:0] {
		ST_NOT_READY = 2'b00,
		ST_READY     = 2'b01,
		ST_STOPPING  = 2'b10,
		ST_RUNOUT    = 2'b11
	} cps_state_type;

endpackage : cps_pkg

// ### verilog/cps_row_if.sv
// row and card check signals between the top and the row checker
`timescale 1ns/1ps
interface cps_row_if;
	import cps_pkg::*;
	logic                row_valid;
	logic [NBITS_W-1:0]  row_nbits;
	logic [ROW_BITS-1:0] row_data;
	logic                card_done;
	logic                read_valid;
	logic [HOLES_W-1:0]  read_holes;
	logic                full_check;
	logic                bits_err;
	logic                count_err;
	logic                hole_err;
	logic [ROWCNT_W-1:0] rows_last;
	logic [HOLES_W-1:0]  holes_exp;

	modport chk (
		input  row_valid, row_nbits, row_data, card_done, read_valid, read_holes, full_check,
		output bits_err, count_err, hole_err, rows_last, holes_exp
	);
	modport top (
		output row_valid, row_nbits, row_data, card_done, read_valid, read_holes, full_check,
		input  bits_err, count_err, hole_err, rows_last, holes_exp
	);
endinterface : cps_row_if

// ### verilog/cps_row_check.sv
// punch station and post-punch hole count checks
`timescale 1ns/1ps
module cps_row_check (
	input wire logic pclk,
	input wire logic presetn,
	cps_row_if.chk   rif
);
	import cps_pkg::*;

	// ==========================================================
	// next values
	logic [NBITS_W-1:0]  ones;
	logic [HOLES_W-1:0]  sum_now;
	logic [ROWCNT_W-1:0] rows_now;
	logic [ROWCNT_W-1:0] rows_r, rows_nxt, rows_last_r, rows_last_nxt;
	logic [HOLES_W-1:0]  holes_r, holes_nxt, exp_r, exp_nxt;
	logic                bits_err_r, bits_err_nxt;
	logic                count_err_r, count_err_nxt;
	logic                hole_err_r, hole_err_nxt;

	always_comb begin
		ones = '0;
		for (int i = 0; i < ROW_BITS; i++) begin
			ones = ones + NBITS_W'(rif.row_data[i]);
		end
		sum_now  = holes_r + (rif.row_valid ? HOLES_W'(ones) : '0);
		rows_now = rows_r;
		if (rif.row_valid && rows_r != '1) begin
			rows_now = rows_r + ROWCNT_W'(1);
		end
		rows_nxt      = rif.card_done ? '0 : rows_now;
		holes_nxt     = rif.card_done ? '0 : sum_now;
		exp_nxt       = rif.card_done ? sum_now : exp_r;
		rows_last_nxt = rif.card_done ? rows_now : rows_last_r;
		// short row
		bits_err_nxt  = rif.row_valid && (rif.row_nbits < NBITS_W'(ROW_BITS));
		// row cycles per card above or below
		count_err_nxt = rif.card_done && (rows_now != ROWCNT_W'(ROWS_PER_CARD));
		// post-punch count only in full check
		hole_err_nxt  = rif.read_valid && rif.full_check && (rif.read_holes != exp_r);
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rows_r      <= '0;
			holes_r     <= '0;
			exp_r       <= '0;
			rows_last_r <= '0;
			bits_err_r  <= 1'b0;
			count_err_r <= 1'b0;
			hole_err_r  <= 1'b0;
		end else begin
			rows_r      <= rows_nxt;
			holes_r     <= holes_nxt;
			exp_r       <= exp_nxt;
			rows_last_r <= rows_last_nxt;
			bits_err_r  <= bits_err_nxt;
			count_err_r <= count_err_nxt;
			hole_err_r  <= hole_err_nxt;
		end
	end

	assign rif.bits_err  = bits_err_r;
	assign rif.count_err = count_err_r;
	assign rif.hole_err  = hole_err_r;
	assign rif.rows_last = rows_last_r;
	assign rif.holes_exp = exp_r;

endmodule : cps_row_check

// ### verilog/cps_irq.sv
// sticky interrupt status with enable and write-one clear
`timescale 1ns/1ps
module cps_irq #(
	parameter int N = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] evt,
	input  wire logic [N-1:0] clr,
	input  wire logic [N-1:0] en,
	output logic      [N-1:0] status,
	output logic              irq
);
	logic [N-1:0] stat_r, stat_nxt;
	logic         irq_r, irq_nxt;

	// ==========================================================
	// set wins over clear
	for (genvar g = 0; g < N; g++) begin : g_bit
		assign stat_nxt[g] = evt[g] | (stat_r[g] & ~clr[g]);
	end

	always_comb begin
		irq_nxt = |(stat_nxt & en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
			irq_r  <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign status = stat_r;
	assign irq    = irq_r;

endmodule : cps_irq

// ### testbench/cps_sva.sv
// checker of the card punch status top module
`timescale 1ns/1ps
module cps_sva (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [cps_pkg::ADDR_W-1:0]   paddr,
	input wire logic [cps_pkg::DATA_W-1:0]   pwdata,
	input wire logic                         pready,
	input wire logic                         card_at_station,
	input wire logic                         feed_fault,
	input wire logic                         auto_eject,
	input wire logic                         transport_open,
	input wire logic                         die_missing,
	input wire logic                         covers_missing,
	input wire logic                         primary_full,
	input wire logic                         aux_full,
	input wire logic                         error_full,
	input wire logic [cps_pkg::CMD_N-1:0]    panel_btn,
	input wire logic                         row_valid,
	input wire logic [cps_pkg::NBITS_W-1:0]  row_nbits,
	input wire logic                         unavailable,
	input wire logic                         feed_check,
	input wire logic                         punch_check,
	input wire logic                         full_check,
	input wire logic                         punch_enable,
	input wire logic                         feed_enable,
	input wire logic                         to_error_stacker
);
	import cps_pkg::*;
	logic [CMD_N-1:0] btn_r;
	logic [2:0]       rst_r;
	logic [2:0]       tog_r;
	logic             wr_ctrl;
	logic             rst_cmd;
	logic             tog_cmd;
	logic             cond;

	// ==========================================================
	// command decode
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == OFF_CTRL;
	assign rst_cmd = (wr_ctrl && pwdata[CMD_RESET]) || (panel_btn[CMD_RESET] && !btn_r[CMD_RESET]);
	assign tog_cmd = (wr_ctrl && pwdata[CMD_CHKMODE])
		|| (panel_btn[CMD_CHKMODE] && !btn_r[CMD_CHKMODE]);
	assign cond = !card_at_station || transport_open || die_missing || covers_missing
		|| primary_full || aux_full || error_full || feed_check || punch_check;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_r <= '0;
			rst_r <= 3'h0;
			tog_r <= 3'h0;
		end else begin
			btn_r <= panel_btn;
			rst_r <= {rst_r[1:0], rst_cmd};
			tog_r <= {tog_r[1:0], tog_cmd};
		end
	end

	// ==========================================================
	// properties
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	unav_cond_a: assert property (cond |-> ##[1:2] unavailable)
		else $error("unavailable missing");
	start_block_a: assert property (unavailable && cond |=> unavailable)
		else $error("left unavailable state");
	feed_set_a: assert property (!card_at_station && feed_fault && !auto_eject |=> feed_check)
		else $error("feed flag not set");
	feed_cause_a: assert property ($rose(feed_check) |->
		$past(!card_at_station && feed_fault && !auto_eject)) else $error("feed flag no cause");
	flag_hold_a: assert property (punch_check && !rst_cmd && rst_r == 3'h0 |=> punch_check)
		else $error("punch flag dropped");
	flag_clear_a: assert property (rst_cmd && card_at_station && !feed_fault
		|-> ##[1:3] !feed_check && !punch_check) else $error("flags not cleared");
	row_bits_a: assert property (row_valid && row_nbits < ROW_BITS |-> ##2 punch_check)
		else $error("short row missed");
	runout_gate_a: assert property (to_error_stacker |-> !punch_enable && !feed_enable)
		else $error("feeding in runout");
	runout_only_a: assert property ($rose(to_error_stacker) |-> $past(unavailable))
		else $error("runout while available");
	mode_toggle_a: assert property ($changed(full_check) |-> tog_r != 3'h0)
		else $error("mode changed unasked");
	cover property ($rose(to_error_stacker));
	cover property ($fell(full_check));
	cover property ($rose(punch_check));
endmodule : cps_sva

bind cps_top cps_sva u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .card_at_station(card_at_station),
	.feed_fault(feed_fault), .auto_eject(auto_eject), .transport_open(transport_open),
	.die_missing(die_missing), .covers_missing(covers_missing), .primary_full(primary_full),
	.aux_full(aux_full), .error_full(error_full), .panel_btn(panel_btn),
	.row_valid(row_valid), .row_nbits(row_nbits), .unavailable(unavailable),
	.feed_check(feed_check), .punch_check(punch_check), .full_check(full_check),
	.punch_enable(punch_enable), .feed_enable(feed_enable),
	.to_error_stacker(to_error_stacker)
);

// ### testbench/cps_host_model.sv
// host side model sending punch rows and read station counts
`timescale 1ns/1ps
module cps_host_model (
	input  wire logic                         pclk,
	output logic                              row_valid,
	output logic [cps_pkg::NBITS_W-1:0]       row_nbits,
	output logic [cps_pkg::ROW_BITS-1:0]      row_data,
	output logic                              card_done,
	output logic                              read_valid,
	output logic [cps_pkg::HOLES_W-1:0]       read_holes
);
	import cps_pkg::*;
	initial {row_valid, row_nbits, row_data, card_done, read_valid, read_holes} = '0;

	// ==========================================================
	// one card, two holes a row, row bad short
	task automatic card(input int nrows, input int bad, input int gap);
		for (int r = 0; r < nrows; r++) begin
			row_valid <= 1'b1;
			row_nbits <= (r == bad) ? 7'h4f : 7'h50;
			row_data <= 80'h3;
			@(posedge pclk);
			row_valid <= 1'b0;
			row_nbits <= 7'h2a;
			row_data <= ~80'h3;
			repeat (gap + 1) @(posedge pclk);
		end
		card_done <= 1'b1;
		@(posedge pclk);
		card_done <= 1'b0;
		@(posedge pclk);
	endtask : card

	task automatic read(input logic [HOLES_W-1:0] h);
		read_valid <= 1'b1;
		read_holes <= h;
		@(posedge pclk);
		read_valid <= 1'b0;
		read_holes <= ~h;
		@(posedge pclk);
	endtask : read
endmodule : cps_host_model

// ### testbench/test_cps_top.sv
// self-checking bench of the card punch status top module
`timescale 1ns/1ps
module test_cps_top;
	import cps_pkg::*;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, pirq;
	logic [ADDR_W-1:0]   paddr;
	logic [DATA_W-1:0]   pwdata, prdata, q;
	logic [CMD_N-1:0]    panel_btn;
	logic [5:0]          flt;
	logic                card, ffault, aeject, busy, lempty, err;
	logic                row_valid, card_done, read_valid;
	logic [NBITS_W-1:0]  row_nbits;
	logic [ROW_BITS-1:0] row_data;
	logic [HOLES_W-1:0]  read_holes;
	logic                unavailable, feed_check, punch_check, full_check;
	logic                punch_enable, feed_enable, transport_run, to_error_stacker;
	int                  n_mismatch, total_checks;
	int                  nr[3] = '{12, 11, 13};

	cps_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pirq(pirq), .card_at_station(card), .feed_fault(ffault), .auto_eject(aeject),
		.transport_open(flt[0]), .die_missing(flt[1]), .covers_missing(flt[2]),
		.primary_full(flt[3]), .aux_full(flt[4]), .error_full(flt[5]),
		.punching_busy(busy), .feed_line_empty(lempty), .panel_btn(panel_btn),
		.row_valid(row_valid), .row_nbits(row_nbits), .row_data(row_data),
		.card_done(card_done), .read_valid(read_valid), .read_holes(read_holes),
		.unavailable(unavailable), .feed_check(feed_check), .punch_check(punch_check),
		.full_check(full_check), .punch_enable(punch_enable), .feed_enable(feed_enable),
		.transport_run(transport_run), .to_error_stacker(to_error_stacker)
	);
	cps_host_model u_host (
		.pclk(pclk), .row_valid(row_valid), .row_nbits(row_nbits), .row_data(row_data),
		.card_done(card_done), .read_valid(read_valid), .read_holes(read_holes)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ==========================================================
	// helpers
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			test_done();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask : rdc

	task automatic cmd(input int b);
		apb(1'b1, OFF_CTRL, 32'h1 << b);
		tick(3);
	endtask : cmd

	task automatic press(input int b);
		panel_btn[b] <= 1'b1;
		tick(2);
		panel_btn[b] <= 1'b0;
		tick(3);
	endtask : press

	// ==========================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, busy, ffault, aeject, paddr, pwdata, panel_btn, flt} = '0;
		{presetn, n_mismatch, total_checks} = '0;
		{card, lempty} = 2'b11;
		tick(4);
		presetn <= 1'b1;
		tick(2);
		rdc("status_rst", OFF_STATUS, 32'h7f, 32'h24);
		rdc("irq_en_rst", OFF_IRQ_EN, 32'hf, 32'h0);
		apb(1'b1, 8'h40, 32'h1f);
		chk("slverr", err, 1'b1);
		chk("unmapped_wr", unavailable, 1'b1);
		$display("test reset done");
		cmd(CMD_START);
		for (int i = 0; i < 7; i++) begin
			if (i == 6) card <= 1'b0;
			else flt[i] <= 1'b1;
			tick(3);
			chk("unav_cond", unavailable, 1'b1);
			cmd(CMD_START);
			chk("start_blk", unavailable, 1'b1);
			flt <= '0;
			card <= 1'b1;
			tick(1);
			cmd(CMD_START);
			chk("restart", unavailable, 1'b0);
			chk("run_en", {punch_enable, feed_enable}, 2'b11);
		end
		$display("test conditions done");
		apb(1'b1, OFF_IRQ_EN, 32'h1);
		card <= 1'b0;
		ffault <= 1'b1;
		aeject <= 1'b1;
		tick(3);
		chk("eject", feed_check, 1'b0);
		chk("irq_mask", pirq, 1'b0);
		aeject <= 1'b0;
		tick(3);
		chk("feed", feed_check, 1'b1);
		chk("irq", pirq, 1'b1);
		ffault <= 1'b0;
		card <= 1'b1;
		tick(3);
		rdc("st_feed", OFF_STATUS, 32'h1c, 32'h0c);
		cmd(CMD_START);
		chk("start_keep", feed_check, 1'b1);
		chk("unav_flag", unavailable, 1'b1);
		cmd(CMD_RESET);
		chk("feed_clr", feed_check, 1'b0);
		rdc("irq_stat", OFF_IRQ_STAT, 32'h1, 32'h1);
		apb(1'b1, OFF_IRQ_CLR, 32'hf);
		tick(2);
		chk("irq_clr", pirq, 1'b0);
		$display("test feed done");
		cmd(CMD_START);
		u_host.card(12, 99, 0);
		tick(4);
		chk("good_card", punch_check, 1'b0);
		rdc("info", OFF_CARD_INFO, 32'h03ff000f, 32'h0018000c);
		u_host.read(10'h18);
		tick(4);
		chk("holes_ok", punch_check, 1'b0);
		u_host.read(10'h17);
		tick(4);
		chk("holes_bad", punch_check, 1'b1);
		cmd(CMD_RESET);
		cmd(CMD_START);
		for (int j = 0; j < 3; j++) begin
			u_host.card(nr[j], (j == 0) ? 5 : 99, j);
			tick(4);
			chk("row_err", punch_check, 1'b1);
			cmd(CMD_RESET);
			chk("punch_clr", punch_check, 1'b0);
			cmd(CMD_START);
		end
		press(CMD_CHKMODE);
		chk("partial", full_check, 1'b0);
		u_host.card(12, 99, 1);
		u_host.read(10'h17);
		tick(4);
		chk("no_post", punch_check, 1'b0);
		press(CMD_CHKMODE);
		chk("full", full_check, 1'b1);
		$display("test checks done");
		apb(1'b1, OFF_IRQ_EN, 32'h8);
		busy <= 1'b1;
		cmd(CMD_STOP);
		rdc("stopping", OFF_STATUS, 32'h7, 32'h2);
		busy <= 1'b0;
		tick(3);
		chk("stopped", unavailable, 1'b1);
		chk("irq_stop", pirq, 1'b1);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(2);
		chk("irq_rst", pirq, 1'b0);
		$display("test stop done");
		cmd(CMD_START);
		lempty <= 1'b0;
		cmd(CMD_RUNOUT);
		chk("ro_ignored", to_error_stacker, 1'b0);
		u_host.card(12, 5, 0);
		tick(4);
		press(CMD_RUNOUT);
		chk("ro_run", transport_run, 1'b1);
		chk("ro_stack", to_error_stacker, 1'b1);
		chk("ro_nopunch", {punch_enable, feed_enable}, 2'b00);
		chk("ro_keep", punch_check, 1'b1);
		lempty <= 1'b1;
		tick(3);
		chk("ro_end", transport_run, 1'b0);
		$display("test runout done");
		test_done();
	end
endmodule : test_cps_top
